// file: shared/spi_shifter_regs.svh
// Timing counts and field constants for the serial shifter
`ifndef SPI_SHIFTER_REGS_SVH
`define SPI_SHIFTER_REGS_SVH

// Bits in one transfer
`define BYTE_BITS 4'h8
`define LAST_BIT 3'h7

// Half periods of SCK in system clocks, normal speed (fosc/4, /16, /64, /128)
`define HALF_NORM_0 7'h02
`define HALF_NORM_1 7'h08
`define HALF_NORM_2 7'h20
`define HALF_NORM_3 7'h40

// Half periods of SCK in system clocks, double speed (fosc/2, /8, /32, /64)
`define HALF_DBL_0 7'h01
`define HALF_DBL_1 7'h04
`define HALF_DBL_2 7'h10
`define HALF_DBL_3 7'h20

`endif

// file: shared/spi_shifter_pkg.sv
// Types shared by the serial shifter
`default_nettype none
package spi_shifter_pkg;
   // Master sequencer states, one-hot
   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,
      ST_RUN = 2'b10
   } master_state_t;
endpackage : spi_shifter_pkg
`default_nettype wire

// file: design/spi_master_slave_shifter.sv
// Byte-wide serial port, master or slave, with receive buffer and done flag
`include "spi_shifter_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module spi_master_slave_shifter (
   input wire logic clk_sys_i,
   input wire logic resetn_i,
   input wire logic sck_i,
   // Software side
   input wire logic enable_i,
   input wire logic master_select_bit_i,
   input wire logic lsb_first_i,
   input wire logic double_speed_i,
   input wire logic [1:0] rate_sel_i,
   input wire logic transfer_irq_enable_i,
   input wire logic data_wr_i,
   input wire logic [7:0] data_wdata_i,
   input wire logic data_rd_i,
   input wire logic status_rd_i,
   input wire logic ss_level_i,
   input wire logic dir_mosi_i,
   input wire logic dir_miso_i,
   input wire logic dir_sck_i,
   input wire logic dir_ss_i,
   output logic [7:0] serial_data_reg_o,
   output logic transfer_done_flag_o,
   output logic write_collision_o,
   output logic irq_o,
   output logic wake_o,
   // Link pins
   input wire logic mosi_i,
   output logic mosi_o,
   output logic mosi_oe_n_o,
   input wire logic miso_i,
   output logic miso_o,
   output logic miso_oe_n_o,
   output logic sck_o,
   output logic sck_oe_n_o,
   input wire logic ss_n_i,
   output logic ss_n_o,
   output logic ss_oe_n_o
);

   // Position of bit n in the byte for the chosen order
   function automatic logic [2:0] bit_index(input logic lsb, input logic [2:0] n);
      bit_index = lsb ? n : 3'(`LAST_BIT - n);
   endfunction : bit_index

   // Shift one received bit into a partial byte
   function automatic logic [7:0] shift_in(input logic lsb, input logic [7:0] sh,
                                           input logic b);
      shift_in = lsb ? {b, sh[7:1]} : {sh[6:0], b};
   endfunction : shift_in

   logic master_en;
   logic slave_en;
   logic [7:0] tx_data;
   logic [7:0] rx_buf;
   logic clear_armed;
   spi_shifter_pkg::master_state_t state;
   logic [6:0] hcnt;
   logic [3:0] rises;
   logic [2:0] falls;
   logic [3:0] scnt;
   logic [7:0] m_rx;
   logic samp_d1;
   logic samp_d2;
   logic ss_s1;
   logic ss_s2;
   logic miso_s1;
   logic miso_s2;
   logic tgl_s1;
   logic tgl_s2;
   logic tgl_s3;
   logic [2:0] l_cnt;
   logic [7:0] l_sh;
   logic [7:0] l_rx_byte;
   logic l_tgl;

   // Mode decode and rate table
   wire link_rst_n = resetn_i & slave_en & ~ss_n_i;  // Deselect resets the slave
   wire running = (state == spi_shifter_pkg::ST_RUN);
   wire [6:0] half_norm = (rate_sel_i == 2'h0) ? `HALF_NORM_0 :
                          (rate_sel_i == 2'h1) ? `HALF_NORM_1 :
                          (rate_sel_i == 2'h2) ? `HALF_NORM_2 : `HALF_NORM_3;
   wire [6:0] half_dbl = (rate_sel_i == 2'h0) ? `HALF_DBL_0 :
                         (rate_sel_i == 2'h1) ? `HALF_DBL_1 :
                         (rate_sel_i == 2'h2) ? `HALF_DBL_2 : `HALF_DBL_3;
   wire [6:0] half = double_speed_i ? half_dbl : half_norm;  // Seven distinct rates

   // Master sequencing terms
   wire start = data_wr_i & master_en & ~running;
   wire collide = data_wr_i & master_en & running;
   wire tick_ok = (rises != `BYTE_BITS) | sck_o;  // No ninth rising edge
   wire tick = running & tick_ok & (hcnt == 7'(half - 7'h01));
   wire rise = tick & ~sck_o;
   wire fall = tick & sck_o;
   wire master_done = running & (scnt == `BYTE_BITS) & (rises == `BYTE_BITS) & ~sck_o;
   wire slave_done = tgl_s2 ^ tgl_s3;
   wire done_evt = master_done | slave_done;
   wire data_access = data_wr_i | data_rd_i;
   wire flag_clear = clear_armed & data_access;
   wire next_flag = done_evt | (transfer_done_flag_o & ~flag_clear);  // Set beats clear
   wire next_wcol = collide | (write_collision_o & ~flag_clear);

   // Slave MISO follows the bit in flight; no extra flop so bit 0 is ready before edge 1
   assign miso_o = slave_en & tx_data[bit_index(lsb_first_i, l_cnt)];

   // Pin synchronisers
   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         ss_s1 <= 1'b1;
         ss_s2 <= 1'b1;
         miso_s1 <= 1'b0;
         miso_s2 <= 1'b0;
         tgl_s1 <= 1'b0;
         tgl_s2 <= 1'b0;
         tgl_s3 <= 1'b0;
      end else begin
         ss_s1 <= ss_n_i;
         ss_s2 <= ss_s1;
         miso_s1 <= miso_i;
         miso_s2 <= miso_s1;
         tgl_s1 <= l_tgl;
         tgl_s2 <= tgl_s1;
         tgl_s3 <= tgl_s2;
      end
   end

   // Mode, transmit holding byte and flags
   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         master_en <= 1'b0;
         slave_en <= 1'b0;
         tx_data <= 8'h00;
         transfer_done_flag_o <= 1'b0;
         write_collision_o <= 1'b0;
         clear_armed <= 1'b0;
         irq_o <= 1'b0;
         wake_o <= 1'b0;
      end else begin
         master_en <= enable_i & master_select_bit_i;
         slave_en <= enable_i & ~master_select_bit_i;
         if (data_wr_i && !running) begin
            tx_data <= data_wdata_i;  // Slave may preload while deselected
         end
         transfer_done_flag_o <= next_flag;
         write_collision_o <= next_wcol;
         if (flag_clear) begin
            clear_armed <= 1'b0;
         end else if (status_rd_i && transfer_done_flag_o) begin
            clear_armed <= 1'b1;
         end
         irq_o <= transfer_done_flag_o & transfer_irq_enable_i;
         wake_o <= done_evt;
      end
   end

   // Receive buffer: a new byte overwrites an unread one
   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         rx_buf <= 8'h00;
      end else if (master_done) begin
         rx_buf <= m_rx;
      end else if (slave_done) begin
         rx_buf <= l_rx_byte;
      end
   end
   assign serial_data_reg_o = rx_buf;

   // Master clock generator and shifter
   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         state <= spi_shifter_pkg::ST_IDLE;
         hcnt <= 7'h00;
         rises <= 4'h0;
         falls <= 3'h0;
         sck_o <= 1'b0;
         mosi_o <= 1'b0;
      end else begin
         case (state)
            spi_shifter_pkg::ST_IDLE: begin
               hcnt <= 7'h00;
               rises <= 4'h0;
               falls <= 3'h0;
               sck_o <= 1'b0;
               if (start) begin
                  mosi_o <= data_wdata_i[bit_index(lsb_first_i, 3'h0)];
                  state <= spi_shifter_pkg::ST_RUN;
               end
            end
            spi_shifter_pkg::ST_RUN: begin
               hcnt <= tick ? 7'h00 : 7'(hcnt + 7'h01);
               if (tick) begin
                  sck_o <= ~sck_o;
               end
               if (rise) begin
                  rises <= 4'(rises + 4'h1);
               end
               if (fall && falls != `LAST_BIT) begin
                  falls <= 3'(falls + 3'h1);
                  mosi_o <= tx_data[bit_index(lsb_first_i, 3'(falls + 3'h1))];
               end
               if (master_done || !master_en) begin
                  state <= spi_shifter_pkg::ST_IDLE;  // Clock stops
               end
            end
            default: begin
               state <= spi_shifter_pkg::ST_IDLE;
            end
         endcase
      end
   end

   // MISO sampled two clocks after each rise, matching the synchroniser delay
   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         samp_d1 <= 1'b0;
         samp_d2 <= 1'b0;
         scnt <= 4'h0;
         m_rx <= 8'h00;
      end else begin
         samp_d1 <= rise;
         samp_d2 <= samp_d1;
         if (start) begin
            scnt <= 4'h0;
         end else if (samp_d2) begin
            scnt <= 4'(scnt + 4'h1);
            m_rx <= shift_in(lsb_first_i, m_rx, miso_s2);
         end
      end
   end

   // Pin direction overrides; port releases all pins while disabled
   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         mosi_oe_n_o <= 1'b1;
         sck_oe_n_o <= 1'b1;
         ss_oe_n_o <= 1'b1;
         ss_n_o <= 1'b1;
         miso_oe_n_o <= 1'b1;
      end else begin
         mosi_oe_n_o <= ~(master_en & dir_mosi_i);
         sck_oe_n_o <= ~(master_en & dir_sck_i);
         ss_oe_n_o <= ~(master_en & dir_ss_i);  // Software owns select
         ss_n_o <= ss_level_i;
         miso_oe_n_o <= ~(slave_en & dir_miso_i & ~ss_s2);
      end
   end

   // Slave shifter on the link clock, held in reset while deselected
   always_ff @(posedge sck_i or negedge link_rst_n) begin
      if (!link_rst_n) begin
         l_cnt <= 3'h0;  // Partial byte dropped
         l_sh <= 8'h00;
      end else begin
         l_cnt <= 3'(l_cnt + 3'h1);
         l_sh <= shift_in(lsb_first_i, l_sh, mosi_i);
      end
   end

   // Completed slave byte and its event toggle survive deselect
   always_ff @(posedge sck_i or negedge resetn_i) begin
      if (!resetn_i) begin
         l_rx_byte <= 8'h00;
         l_tgl <= 1'b0;
      end else if (link_rst_n && l_cnt == `LAST_BIT) begin
         l_rx_byte <= shift_in(lsb_first_i, l_sh, mosi_i);
         l_tgl <= ~l_tgl;
      end
   end

   // Checks
   logic [3:0] seen_rises;
   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         seen_rises <= 4'h0;
      end else if (start) begin
         seen_rises <= 4'h0;
      end else if (running && sck_o && !$past(sck_o)) begin
         seen_rises <= 4'(seen_rises + 4'h1);
      end
   end

   sequence status_seen_s;
      status_rd_i && transfer_done_flag_o && !done_evt;
   endsequence
   sequence data_touch_s;
      data_access && !done_evt && !status_rd_i;
   endsequence

   eight_rises_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
      master_done |-> seen_rises == `BYTE_BITS)
      else $error("master transfer did not give eight SCK rises");
   // A new write may follow at once, so SCK is only held low until the restart can act
   clock_stops_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
      master_done |=> !running && !sck_o ##1 !sck_o)
      else $error("SCK moved after the byte ended");
   flag_sets_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
      done_evt |=> transfer_done_flag_o && wake_o)
      else $error("done flag or wake pulse missing after transfer");
   irq_follows_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
      transfer_done_flag_o && transfer_irq_enable_i |=> irq_o)
      else $error("interrupt request missing");
   rx_keeps_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
      master_done |=> serial_data_reg_o == $past(m_rx))
      else $error("received byte not kept in buffer");
   miso_release_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
      slave_en && ss_s2 |=> miso_oe_n_o)
      else $error("MISO driven while deselected");
   tx_guard_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
      collide |=> $stable(tx_data) && write_collision_o)
      else $error("write during transfer disturbed the byte");
   master_pins_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
      master_en |=> miso_oe_n_o && ss_n_o == $past(ss_level_i))
      else $error("master pin override wrong");
   flag_clear_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
      status_seen_s ##1 data_touch_s |=> !transfer_done_flag_o)
      else $error("done flag not cleared by status then data access");
   // Deselect falls between bytes, so the check must not be cut off by the link reset
   slave_byte_a: assert property (@(posedge sck_i) disable iff (!resetn_i)
      link_rst_n && l_cnt == `LAST_BIT |=> l_tgl != $past(l_tgl))
      else $error("slave byte end not signalled");

endmodule : spi_master_slave_shifter
`default_nettype wire

// file: sim/spi_far_end.sv
// Far-end model: slave responder for master runs, SCK master for slave runs
`timescale 1ns/1ps
`default_nettype none
module spi_far_end (
   input wire logic link_clk_i,
   input wire logic lsb_i,
   input wire logic sck_w_i,
   input wire logic mosi_w_i,
   input wire logic miso_w_i,
   input wire logic ss_w_i,
   output logic p_sck_o,
   output logic p_mosi_o,
   output logic p_ss_n_o,
   output logic p_miso_o
);
   logic [7:0] resp_tx;
   logic [7:0] resp_rx;
   int resp_cnt;
   initial begin
      p_sck_o = 1'b0;
      p_mosi_o = 1'b0;
      p_ss_n_o = 1'b1;
      p_miso_o = 1'b0;
      resp_tx = 8'h00;
      resp_cnt = 0;
   end
   function automatic logic pick(input logic [7:0] b, input int k);
      return lsb_i ? b[k] : b[7-k];
   endfunction : pick
   // Responder: first bit on select, next bit after each fall
   always @(negedge ss_w_i) begin
      resp_cnt = 0;
      p_miso_o = pick(resp_tx, 0);
   end
   always @(posedge sck_w_i) if (!ss_w_i) begin
      resp_rx = lsb_i ? {mosi_w_i, resp_rx[7:1]} : {resp_rx[6:0], mosi_w_i};
      resp_cnt++;
   end
   // No pull on MISO, so a released line shows the inverse, not a kept value
   always @(negedge sck_w_i) if (!ss_w_i) begin
      p_miso_o = resp_cnt < 8 ? pick(resp_tx, resp_cnt) : ~p_miso_o;
   end
   always @(posedge ss_w_i) p_miso_o = ~p_miso_o;
   // Half period of 4 link cycles keeps SCK below a quarter of system clock
   task automatic frame(input logic [7:0] tx, input int nbits, input logic sel,
                        output logic [7:0] rx);
      rx = 8'h00;
      @(posedge link_clk_i);
      p_ss_n_o = !sel;
      repeat (8) @(posedge link_clk_i);
      for (int k = 0; k < nbits; k++) begin
         p_mosi_o = pick(tx, k);
         repeat (4) @(posedge link_clk_i);
         rx = lsb_i ? {miso_w_i, rx[7:1]} : {rx[6:0], miso_w_i};
         p_sck_o = 1'b1;
         repeat (4) @(posedge link_clk_i);
         p_sck_o = 1'b0;
      end
      repeat (4) @(posedge link_clk_i);
      p_ss_n_o = 1'b1;
      p_mosi_o = ~p_mosi_o;
   endtask : frame
endmodule : spi_far_end
`default_nettype wire

// file: sim/testbench.sv
// Self-checking bench for the serial shifter in master and slave mode
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic clk_sys = 0, resetn = 0, link_clk = 0;
   logic en = 0, mst = 0, lsb = 0, dbl = 0, irq_en = 0, wr = 0, rd = 0, srd = 0, ss_lvl = 1;
   logic [1:0] rsel = 2'h0;
   logic [7:0] wdata = 8'h00;
   logic [7:0] rdata;
   logic flag, wcol, irq, wake, mosi_o, mosi_oe_n, miso_o, miso_oe_n;
   logic sck_o, sck_oe_n, ss_o, ss_oe_n, p_sck, p_mosi, p_ss_n, p_miso;
   wire sck_w = !sck_oe_n ? sck_o : p_sck;
   wire mosi_w = !mosi_oe_n ? mosi_o : p_mosi;
   wire miso_w = !miso_oe_n ? miso_o : p_miso;
   wire ss_w = !ss_oe_n ? ss_o : p_ss_n;
   int n_mismatch = 0, n_tests = 0;
   int half_tab[8] = '{2, 8, 32, 64, 1, 4, 16, 32};
   logic [7:0] expq[$];
   logic [7:0] last;
   logic [3:0] dirs = 4'hF;
   logic [31:0] seed = 32'h0001_4224;
   always #25 clk_sys = ~clk_sys;
   // Link base clock, offset so it never lines up with the system clock
   initial begin
      #7;
      forever #15 link_clk = ~link_clk;
   end
   spi_master_slave_shifter uut (.clk_sys_i(clk_sys), .resetn_i(resetn), .sck_i(sck_w),
      .enable_i(en), .master_select_bit_i(mst), .lsb_first_i(lsb), .double_speed_i(dbl),
      .rate_sel_i(rsel), .transfer_irq_enable_i(irq_en), .data_wr_i(wr),
      .data_wdata_i(wdata), .data_rd_i(rd), .status_rd_i(srd), .ss_level_i(ss_lvl),
      .dir_mosi_i(dirs[3]), .dir_miso_i(dirs[2]), .dir_sck_i(dirs[1]), .dir_ss_i(dirs[0]),
      .serial_data_reg_o(rdata), .transfer_done_flag_o(flag), .write_collision_o(wcol),
      .irq_o(irq), .wake_o(wake), .mosi_i(mosi_w), .mosi_o(mosi_o),
      .mosi_oe_n_o(mosi_oe_n), .miso_i(miso_w), .miso_o(miso_o), .miso_oe_n_o(miso_oe_n),
      .sck_o(sck_o), .sck_oe_n_o(sck_oe_n), .ss_n_i(ss_w), .ss_n_o(ss_o),
      .ss_oe_n_o(ss_oe_n));
   spi_far_end far (.link_clk_i(link_clk), .lsb_i(lsb), .sck_w_i(sck_w), .mosi_w_i(mosi_w),
      .miso_w_i(miso_w), .ss_w_i(ss_w), .p_sck_o(p_sck), .p_mosi_o(p_mosi),
      .p_ss_n_o(p_ss_n), .p_miso_o(p_miso));
   function automatic logic [7:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed[7:0];
   endfunction : rnd
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      n_tests++;
      if (got !== exp) begin
         n_mismatch++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic conclude();
      $display("mismatches %0d of %0d checks", n_mismatch, n_tests);
      if (n_mismatch == 0 && n_tests > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : conclude
   // Scoreboard: each completed byte takes the oldest expected byte
   always @(negedge clk_sys) if (resetn && wake === 1'b1) begin
      chk("rx byte", expq.size() ? expq.pop_front() : 8'hxx, rdata);
      chk("done flag", 8'h01, {7'h00, flag});
      @(negedge clk_sys);
      chk("irq", {7'h00, irq_en}, {7'h00, irq});
   end
   // Master byte at one rate; at rate index 3 a second write mid-run must be refused
   task automatic mxfer(input logic [3:0] i, input logic [7:0] tx, input logic [7:0] srx);
      int h;
      int n;
      h = half_tab[i[2:0]];
      n = 0;
      @(negedge clk_sys);
      {dbl, rsel} = i[2:0];
      lsb = tx[0];
      irq_en = tx[1];
      far.resp_tx = srx;
      ss_lvl = 1'b0;
      expq.push_back(srx);
      @(negedge clk_sys);
      wr = 1'b1;
      wdata = tx;
      @(negedge clk_sys);
      wr = (i == 4'h3);
      wdata = ~tx;
      @(negedge clk_sys);
      wr = 1'b0;
      while (wake !== 1'b1 && n < 3000) begin
         @(negedge clk_sys);
         n++;
      end
      chk("rate", 8'h01, {7'h00, (n + 2 >= 16 * h) && (n + 2 <= 16 * h + 8)});
      chk("far rx", tx, far.resp_rx);
      chk("ss kept", 8'h00, {7'h00, ss_o});
      // Collision flag stays up until the status-then-data clear
      chk("collision", {7'h00, i >= 4'h3}, {7'h00, wcol});
      last = srx;
      @(negedge clk_sys);
      ss_lvl = 1'b1;
      @(negedge clk_sys);
   endtask : mxfer
   // Slave byte: optional write, then a frame from the far master
   task automatic sxfer(input logic w, input logic [7:0] tx, input logic [7:0] mtx,
                        input int nbits, input logic sel);
      logic [7:0] got;
      @(negedge clk_sys);
      lsb = mtx[0];
      irq_en = mtx[1];
      wr = w;
      wdata = tx;
      if (nbits == 8 && sel) expq.push_back(mtx);
      @(negedge clk_sys);
      wr = 1'b0;
      if (w) chk("rx kept", last, rdata);
      far.frame(mtx, nbits, sel, got);
      repeat (8) @(negedge clk_sys);
      if (nbits == 8 && sel) chk("slave tx", tx, got);
      if (nbits == 8 && sel) last = mtx;
   endtask : sxfer
   initial begin
      // Longest path is about 2900 cycles; 1 ms leaves ample margin
      #1000000;
      n_mismatch++;
      $display("BAD watchdog expected finish seen timeout");
      conclude();
   end
   initial begin
      logic [7:0] a;
      repeat (10) @(negedge clk_sys);
      resetn = 1'b1;
      @(negedge clk_sys);
      en = 1'b1;
      mst = 1'b1;
      repeat (2) @(negedge clk_sys);
      chk("master dirs", 8'h08, {4'h0, miso_oe_n, mosi_oe_n, sck_oe_n, ss_oe_n});
      // User directions must reach the master pins; MISO stays an input regardless
      dirs = 4'h5;
      repeat (2) @(negedge clk_sys);
      chk("user dirs", 8'h0E, {4'h0, miso_oe_n, mosi_oe_n, sck_oe_n, ss_oe_n});
      dirs = 4'hF;
      for (int i = 0; i < 8; i++) mxfer(i[3:0], rnd(), rnd());
      chk("overwrite", last, rdata);
      @(negedge clk_sys);
      srd = 1'b1;
      @(negedge clk_sys);
      srd = 1'b0;
      rd = 1'b1;
      @(negedge clk_sys);
      rd = 1'b0;
      @(negedge clk_sys);
      chk("flag clear", 8'h00, {6'h00, flag, wcol});
      $display("test master done");
      mst = 1'b0;
      repeat (3) @(negedge clk_sys);
      chk("slave idle", 8'h0F, {4'h0, miso_oe_n, mosi_oe_n, sck_oe_n, ss_oe_n});
      a = rnd();
      sxfer(1'b1, a, rnd(), 8, 1'b0);
      sxfer(1'b0, a, rnd(), 8, 1'b1);
      a = rnd();
      sxfer(1'b1, a, rnd(), 5, 1'b1);
      sxfer(1'b0, a, rnd(), 8, 1'b1);
      sxfer(1'b1, rnd(), rnd(), 8, 1'b1);
      chk("pending", 8'h00, 8'(expq.size()));
      $display("test slave done");
      conclude();
   end
endmodule : testbench
`default_nettype wire
